// ===== dv/prc_operator_model.sv
// Operator and trigger source: bouncing contacts and a quadrature dial.
// Assumes the bench calls its tasks; every line changes on the falling clock edge.
`timescale 1ns/1ps
module prc_operator_model
    import prc_pkg::*;
#(
    parameter int HoldCycles = 12
)
(
    input  wire logic core_clk,
    output logic      startBtn,
    output logic      stopBtn,
    output logic      modeBtn,
    output logic      fnSelBtn,
    output logic      fnEntBtn,
    output logic      fnClrBtn,
    output logic      trigIn,
    output logic      dialA,
    output logic      dialB
);
    logic [BTN_NUM-1:0] btnLvl = '0;

    assign startBtn = btnLvl[BTN_START];
    assign stopBtn  = btnLvl[BTN_STOP];
    assign modeBtn  = btnLvl[BTN_MODE];
    assign fnSelBtn = btnLvl[BTN_FSEL];
    assign fnEntBtn = btnLvl[BTN_FENT];
    assign fnClrBtn = btnLvl[BTN_FCLR];
    assign trigIn   = btnLvl[BTN_TRIG];
    initial
    begin
        dialA = 1'b0;
        dialB = 1'b0;
    end

    // Real contacts chatter, so each change bounces for a few single cycles first.
    task automatic drive(input int idx, input logic val);
        repeat (3)
        begin
            btnLvl[idx] = val;
            @(negedge core_clk);
            btnLvl[idx] = ~val;
            @(negedge core_clk);
        end
        btnLvl[idx] = val;
        repeat (HoldCycles) @(negedge core_clk);
    endtask : drive

    task automatic click(input int idx);
        drive(idx, 1'b1);
        drive(idx, 1'b0);
    endtask : click

    // Phase A rises with B low for a step up and with B high for a step down.
    task automatic turn(input logic up);
        logic [3:0] seqA;
        logic [3:0] seqB;
        seqA = up ? 4'hc : 4'h6;
        seqB = up ? 4'h6 : 4'hc;
        for (int i = 3; i >= 0; i--)
        begin
            dialA = seqA[i];
            dialB = seqB[i];
            repeat (4) @(negedge core_clk);
        end
    endtask : turn
endmodule : prc_operator_model

// ===== dv/prc_run_ctrl_tb.sv
// Self-checking bench for the run control block, walking every mode in turn.
// Assumes a short debounce count so that each contact press settles in a few cycles.
`timescale 1ns/1ps
module prc_run_ctrl_tb;
    import prc_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic startBtn, stopBtn, modeBtn, fnSelBtn, fnEntBtn, fnClrBtn, trigIn, dialA, dialB;
    logic dispenseDone = 1'b0;
    logic chamberEmpty = 1'b0;
    logic pumpRun, pumpDirRev, portB, loadReq, startLampGreen, stopLampRed;
    logic [4:0]         modeShown;
    logic [1:0]         selParam;
    logic [PARAM_W-1:0] shownVal;
    logic               loadSeen = 1'b0;
    int                 errorCnt = 0;
    int                 cmpCount = 0;

    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) if (loadReq === 1'b1) loadSeen <= 1'b1;

    prc_operator_model op (.core_clk(core_clk), .startBtn(startBtn), .stopBtn(stopBtn),
        .modeBtn(modeBtn), .fnSelBtn(fnSelBtn), .fnEntBtn(fnEntBtn), .fnClrBtn(fnClrBtn),
        .trigIn(trigIn), .dialA(dialA), .dialB(dialB));

    prc_run_ctrl #(.DebCycles(4)) uut (.core_clk(core_clk), .rst(rst), .startBtn(startBtn),
        .stopBtn(stopBtn), .modeBtn(modeBtn), .fnSelBtn(fnSelBtn), .fnEntBtn(fnEntBtn),
        .fnClrBtn(fnClrBtn), .trigIn(trigIn), .dialA(dialA), .dialB(dialB),
        .dispenseDone(dispenseDone), .chamberEmpty(chamberEmpty), .pumpRun(pumpRun),
        .pumpDirRev(pumpDirRev), .portB(portB), .loadReq(loadReq),
        .startLampGreen(startLampGreen), .stopLampRed(stopLampRed),
        .modeShown(modeShown), .selParam(selParam), .shownVal(shownVal));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // The lamps are checked with the run line since they must always agree with it.
    task automatic chkRun(input logic exp);
        chk("pumpRun", {15'h0000, pumpRun}, {15'h0000, exp});
        chk("startLampGreen", {15'h0000, startLampGreen}, {15'h0000, exp});
        chk("stopLampRed", {15'h0000, stopLampRed}, {15'h0000, ~exp});
    endtask : chkRun

    task automatic pulseIn(input bit empty);
        if (empty) chamberEmpty = 1'b1;
        else dispenseDone = 1'b1;
        @(negedge core_clk);
        dispenseDone = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask : pulseIn

    task automatic test_setup();
        chkRun(1'b0);
        chk("modeShown", {11'h000, modeShown}, {11'h000, MODE_SETUP});
        op.click(BTN_START);
        chkRun(1'b0);
        op.turn(1'b1);
        op.turn(1'b1);
        chk("shownVal", shownVal, 16'h0002);
        op.turn(1'b0);
        chk("shownVal", shownVal, 16'h0001);
        op.click(BTN_FENT);
        op.click(BTN_FSEL);
        chk("selParam", {14'h0000, selParam}, 16'h0001);
        chk("shownVal", shownVal, 16'h0000);
        repeat (3) op.click(BTN_FSEL);
        chk("selParam", {14'h0000, selParam}, 16'h0000);
        chk("shownVal", shownVal, 16'h0001);
        op.click(BTN_FCLR);
        chk("shownVal", shownVal, 16'h0000);
        op.click(BTN_FENT);
        $display("test setup done");
    endtask : test_setup

    task automatic test_prime();
        op.click(BTN_MODE);
        chk("modeShown", {11'h000, modeShown}, {11'h000, MODE_PRIME});
        op.turn(1'b1);
        chk("shownVal", shownVal, 16'h0000);
        op.click(BTN_TRIG);
        chkRun(1'b0);
        op.click(BTN_FSEL);
        chk("pumpDirRev", {15'h0000, pumpDirRev}, 16'h0001);
        op.click(BTN_FENT);
        chk("portB", {15'h0000, portB}, 16'h0001);
        op.click(BTN_FCLR);
        chk("loadReq", {15'h0000, loadSeen}, 16'h0001);
        op.drive(BTN_START, 1'b1);
        chkRun(1'b1);
        op.drive(BTN_START, 1'b0);
        repeat (40) @(negedge core_clk);
        chkRun(1'b1);
        op.click(BTN_MODE);
        chk("modeShown", {11'h000, modeShown}, {11'h000, MODE_PRIME});
        op.drive(BTN_STOP, 1'b1);
        chkRun(1'b0);
        op.drive(BTN_STOP, 1'b0);
        $display("test prime done");
    endtask : test_prime

    task automatic test_dispense();
        op.click(BTN_MODE);
        chk("modeShown", {11'h000, modeShown}, {11'h000, MODE_DISPENSE});
        op.drive(BTN_TRIG, 1'b1);
        chkRun(1'b1);
        op.drive(BTN_TRIG, 1'b0);
        op.drive(BTN_TRIG, 1'b1);
        chkRun(1'b1);
        pulseIn(1'b0);
        chkRun(1'b0);
        repeat (20) @(negedge core_clk);
        chkRun(1'b0);
        op.drive(BTN_TRIG, 1'b0);
        op.click(BTN_START);
        chkRun(1'b1);
        pulseIn(1'b0);
        chkRun(1'b0);
        $display("test dispense done");
    endtask : test_dispense

    task automatic test_meter();
        op.click(BTN_MODE);
        chk("modeShown", {11'h000, modeShown}, {11'h000, MODE_METER});
        op.drive(BTN_TRIG, 1'b1);
        chkRun(1'b1);
        op.drive(BTN_TRIG, 1'b0);
        chkRun(1'b0);
        op.drive(BTN_TRIG, 1'b1);
        chkRun(1'b1);
        pulseIn(1'b1);
        chkRun(1'b0);
        chamberEmpty = 1'b0;
        repeat (20) @(negedge core_clk);
        chkRun(1'b0);
        op.drive(BTN_TRIG, 1'b0);
        $display("test meter done");
    endtask : test_meter

    task automatic test_bubble();
        op.click(BTN_MODE);
        chk("modeShown", {11'h000, modeShown}, {11'h000, MODE_BUBBLE});
        op.click(BTN_TRIG);
        chkRun(1'b0);
        op.click(BTN_START);
        chkRun(1'b1);
        op.click(BTN_STOP);
        chkRun(1'b0);
        op.click(BTN_MODE);
        chk("modeShown", {11'h000, modeShown}, {11'h000, MODE_SETUP});
        $display("test bubble done");
    endtask : test_bubble

    // A hang anywhere in the sequence ends the run here instead of stalling forever.
    initial
    begin
        repeat (20000) @(posedge core_clk);
        errorCnt++;
        stop_test();
    end

    initial
    begin
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        test_setup();
        test_prime();
        test_dispense();
        test_meter();
        test_bubble();
        stop_test();
    end
endmodule : prc_run_ctrl_tb

// ===== rtl/prc_debounce.sv
// Two-flop synchroniser followed by a stability counter for one contact input.
// Assumes the raw input may bounce and is asynchronous to core_clk.
`timescale 1ns/1ps
module prc_debounce
    import prc_pkg::*;
#(
    parameter int Cycles = DEB_CYCLES
)
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic rawIn,
    output logic      levelOut,
    output logic      riseOut
);

    logic                 sync1_q;
    logic                 sync2_q;
    logic [DEB_CNT_W-1:0] cnt_q;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= rawIn;
            sync2_q <= sync1_q;
        end
    end

    // A new level is taken only after it has held for the whole window.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q    <= '0;
            levelOut <= 1'b0;
            riseOut  <= 1'b0;
        end
        else
        begin
            riseOut <= 1'b0;
            if (sync2_q == levelOut)
                cnt_q <= '0;
            else if (cnt_q == DEB_CNT_W'(Cycles - 1))
            begin
                cnt_q    <= '0;
                levelOut <= sync2_q;
                riseOut  <= sync2_q;
            end
            else
                cnt_q <= cnt_q + DEB_CNT_W'(1);
        end
    end

endmodule : prc_debounce

// ===== rtl/prc_dial.sv
// Quadrature decoder for the front-panel dial, one step per rising edge of phase A.
// Assumes a detented encoder slow enough that the phases never change in one cycle.
`timescale 1ns/1ps
module prc_dial
    import prc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic phaseA,
    input  wire logic phaseB,
    output logic      stepUp,
    output logic      stepDown
);

    logic aMeta_q;
    logic aSync_q;
    logic aPrev_q;
    logic bMeta_q;
    logic bSync_q;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            aMeta_q <= 1'b0;
            aSync_q <= 1'b0;
            bMeta_q <= 1'b0;
            bSync_q <= 1'b0;
            aPrev_q <= 1'b0;
        end
        else
        begin
            aMeta_q <= phaseA;
            aSync_q <= aMeta_q;
            bMeta_q <= phaseB;
            bSync_q <= bMeta_q;
            aPrev_q <= aSync_q;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            stepUp   <= 1'b0;
            stepDown <= 1'b0;
        end
        else
        begin
            stepUp   <= aSync_q & ~aPrev_q & ~bSync_q;
            stepDown <= aSync_q & ~aPrev_q & bSync_q;
        end
    end

endmodule : prc_dial

// ===== rtl/prc_pkg.sv
// Shared constants and types for the pump run and trigger control block.
// Assumes a single 25 MHz system clock and an active high asynchronous reset.
package prc_pkg;

    localparam int CLK_FREQ_MHZ = 25;
    localparam int DEB_TIME_US  = 10000;
    localparam int DEB_CYCLES   = DEB_TIME_US * CLK_FREQ_MHZ;
    localparam int DEB_CNT_W    = 18;

    localparam int BTN_START = 0;
    localparam int BTN_STOP  = 1;
    localparam int BTN_MODE  = 2;
    localparam int BTN_FSEL  = 3;
    localparam int BTN_FENT  = 4;
    localparam int BTN_FCLR  = 5;
    localparam int BTN_TRIG  = 6;
    localparam int BTN_NUM   = 7;

    localparam int              PARAM_W     = 16;
    localparam int              PARAM_NUM   = 4;
    localparam logic [1:0]      PARAM_LAST  = 2'h3;
    localparam logic [15:0]     PARAM_RST   = 16'h0000;
    localparam logic [15:0]     PARAM_MIN   = 16'h0000;
    localparam logic [15:0]     PARAM_MAX   = 16'hffff;
    localparam logic [15:0]     PARAM_STEP  = 16'h0001;

    typedef enum logic [4:0] {
        MODE_SETUP    = 5'h01,
        MODE_PRIME    = 5'h02,
        MODE_DISPENSE = 5'h04,
        MODE_METER    = 5'h08,
        MODE_BUBBLE   = 5'h10
    } prc_mode_t;

    typedef enum logic [4:0] {
        RUN_IDLE   = 5'h01,
        RUN_PRIME  = 5'h02,
        RUN_DISP   = 5'h04,
        RUN_METER  = 5'h08,
        RUN_BUBBLE = 5'h10
    } prc_run_t;

endpackage : prc_pkg

// ===== rtl/prc_run_ctrl.sv
// Run control for the dispensing controller: mode selection, setup editing,
// start and stop handling, external trigger handling and button lamps.
// Assumes push-buttons and trigger are raw contacts; the motion block reports
// dispense completion and an empty chamber as levels or pulses on core_clk.
`timescale 1ns/1ps
module prc_run_ctrl
    import prc_pkg::*;
#(
    parameter int DebCycles = DEB_CYCLES
)
(
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               startBtn,
    input  wire logic               stopBtn,
    input  wire logic               modeBtn,
    input  wire logic               fnSelBtn,
    input  wire logic               fnEntBtn,
    input  wire logic               fnClrBtn,
    input  wire logic               trigIn,
    input  wire logic               dialA,
    input  wire logic               dialB,
    input  wire logic               dispenseDone,
    input  wire logic               chamberEmpty,
    output logic                    pumpRun,
    output logic                    pumpDirRev,
    output logic                    portB,
    output logic                    loadReq,
    output logic                    startLampGreen,
    output logic                    stopLampRed,
    output logic [4:0]              modeShown,
    output logic [1:0]              selParam,
    output logic [PARAM_W-1:0]      shownVal
);

    logic [BTN_NUM-1:0] rawBtn;
    logic [BTN_NUM-1:0] btnLevel;
    logic [BTN_NUM-1:0] btnRise;
    logic               dialUp;
    logic               dialDown;

    prc_mode_t          mode_q;
    prc_mode_t          mode_d;
    prc_run_t           run_q;
    prc_run_t           run_d;
    logic [PARAM_W-1:0] params_q [PARAM_NUM];
    logic [PARAM_W-1:0] editVal_q;

    logic startEv;
    logic stopEv;
    logic modeEv;
    logic trigRise;
    logic trigLevel;
    logic idle;

    assign rawBtn = {trigIn, fnClrBtn, fnEntBtn, fnSelBtn, modeBtn, stopBtn, startBtn};

    // One debouncer per contact keeps bounce from looking like several edges.
    generate
        for (genvar i = 0; i < BTN_NUM; i++)
        begin : g_deb
            prc_debounce #(
                .Cycles   (DebCycles)
            ) u_deb (
                .core_clk (core_clk),
                .rst      (rst),
                .rawIn    (rawBtn[i]),
                .levelOut (btnLevel[i]),
                .riseOut  (btnRise[i])
            );
        end
    endgenerate

    prc_dial u_dial (
        .core_clk (core_clk),
        .rst      (rst),
        .phaseA   (dialA),
        .phaseB   (dialB),
        .stepUp   (dialUp),
        .stepDown (dialDown)
    );

    assign startEv   = btnRise[BTN_START];
    assign stopEv    = btnRise[BTN_STOP];
    assign modeEv    = btnRise[BTN_MODE];
    assign trigRise  = btnRise[BTN_TRIG];
    assign trigLevel = btnLevel[BTN_TRIG];
    assign idle      = (run_q == RUN_IDLE);

    // Mode changes are refused while pumping so a run never changes its meaning midway.
    always_comb
    begin
        mode_d = mode_q;
        if (modeEv && idle)
        begin
            unique case (mode_q)
                MODE_SETUP:    mode_d = MODE_PRIME;
                MODE_PRIME:    mode_d = MODE_DISPENSE;
                MODE_DISPENSE: mode_d = MODE_METER;
                MODE_METER:    mode_d = MODE_BUBBLE;
                MODE_BUBBLE:   mode_d = MODE_SETUP;
                default:       mode_d = MODE_SETUP;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            mode_q <= MODE_SETUP;
        else
            mode_q <= mode_d;
    end

    always_comb
    begin
        run_d = run_q;
        unique case (run_q)
            RUN_IDLE:
            begin
                if (stopEv)
                    run_d = RUN_IDLE;
                else if (mode_q == MODE_PRIME && startEv)
                    run_d = RUN_PRIME;
                else if (mode_q == MODE_BUBBLE && startEv)
                    run_d = RUN_BUBBLE;
                else if (mode_q == MODE_DISPENSE && (startEv || trigRise))
                    run_d = RUN_DISP;
                else if (mode_q == MODE_METER && trigRise && !chamberEmpty)
                    run_d = RUN_METER;
                else if (mode_q == MODE_METER && startEv && !chamberEmpty)
                    run_d = RUN_METER;
            end
            RUN_PRIME, RUN_BUBBLE:
            begin
                if (stopEv)
                    run_d = RUN_IDLE;
            end
            RUN_DISP:
            begin
                if (stopEv || dispenseDone)
                    run_d = RUN_IDLE;
            end
            RUN_METER:
            begin
                if (stopEv || chamberEmpty || !trigLevel)
                    run_d = RUN_IDLE;
            end
            default: run_d = RUN_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            run_q <= RUN_IDLE;
        else
            run_q <= run_d;
    end

    // Lamps share the next state with the run flag so they never disagree with it.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pumpRun        <= 1'b0;
            startLampGreen <= 1'b0;
            stopLampRed    <= 1'b1;
            modeShown      <= MODE_SETUP;
        end
        else
        begin
            pumpRun        <= (run_d != RUN_IDLE);
            startLampGreen <= (run_d != RUN_IDLE);
            stopLampRed    <= (run_d == RUN_IDLE);
            modeShown      <= mode_d;
        end
    end

    // Function buttons act on what their display field holds in this mode.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pumpDirRev <= 1'b0;
            portB      <= 1'b0;
            loadReq    <= 1'b0;
            selParam   <= 2'h0;
        end
        else
        begin
            loadReq <= 1'b0;
            if (mode_q == MODE_SETUP)
            begin
                if (btnRise[BTN_FSEL])
                    selParam <= (selParam == PARAM_LAST) ? 2'h0 : selParam + 2'h1;
            end
            else if (idle)
            begin
                if (btnRise[BTN_FSEL] && mode_q != MODE_BUBBLE)
                    pumpDirRev <= ~pumpDirRev;
                if (btnRise[BTN_FENT])
                    portB <= ~portB;
                if (btnRise[BTN_FCLR] && mode_q != MODE_BUBBLE)
                    loadReq <= 1'b1;
            end
        end
    end

    // A new value only reaches the store on Enter; leaving Setup drops the edit.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            editVal_q <= PARAM_RST;
            for (int i = 0; i < PARAM_NUM; i++)
                params_q[i] <= PARAM_RST;
        end
        else if (mode_q != MODE_SETUP)
            editVal_q <= params_q[selParam];
        else if (btnRise[BTN_FSEL])
            editVal_q <= params_q[(selParam == PARAM_LAST) ? 2'h0 : selParam + 2'h1];
        else if (btnRise[BTN_FENT])
            params_q[selParam] <= editVal_q;
        else if (btnRise[BTN_FCLR])
            editVal_q <= PARAM_MIN;
        else if (dialUp && editVal_q != PARAM_MAX)
            editVal_q <= editVal_q + PARAM_STEP;
        else if (dialDown && editVal_q != PARAM_MIN)
            editVal_q <= editVal_q - PARAM_STEP;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            shownVal <= PARAM_RST;
        else
            shownVal <= editVal_q;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    start_run_a: assert property (idle && mode_q == MODE_PRIME && startEv && !stopEv
        |=> pumpRun) else $error("start did not run prime");
    lamp_green_a: assert property (##1 startLampGreen == (run_q != RUN_IDLE)
        && stopLampRed == (run_q == RUN_IDLE) && pumpRun == (run_q != RUN_IDLE))
        else $error("lamps disagree with run state");
    stop_halt_a: assert property (stopEv |=> !pumpRun && stopLampRed)
        else $error("stop did not halt pump");
    mode_step_a: assert property (modeEv && idle |=> ##1 modeShown != $past(modeShown, 2))
        else $error("mode did not advance");
    mode_legal_a: assert property ($onehot(mode_q)) else $error("illegal mode");
    dial_setup_a: assert property (mode_q != MODE_SETUP |=> $stable(params_q[0]))
        else $error("value changed outside setup");
    trig_edge_a: assert property (idle && mode_q == MODE_DISPENSE && trigRise && !stopEv
        |=> pumpRun) else $error("trigger edge did not start");
    prime_notrig_a: assert property (idle && (mode_q == MODE_PRIME || mode_q == MODE_BUBBLE)
        && !startEv |=> !pumpRun) else $error("trigger started prime");
    disp_hold_a: assert property (run_q == RUN_DISP && !dispenseDone && !stopEv
        |=> run_q == RUN_DISP) else $error("dispense ended early");
    meter_end_a: assert property (run_q == RUN_METER && (!trigLevel || chamberEmpty)
        |=> !pumpRun) else $error("meter did not end");
    prime_hold_a: assert property (run_q == RUN_PRIME && !stopEv |=> run_q == RUN_PRIME)
        else $error("prime stopped on its own");

    prime_run_c: cover property (run_q == RUN_PRIME ##1 run_q == RUN_IDLE);
    disp_run_c: cover property (run_q == RUN_DISP ##1 run_q == RUN_IDLE);
    meter_run_c: cover property (run_q == RUN_METER ##1 run_q == RUN_IDLE);
    setup_edit_c: cover property (mode_q == MODE_SETUP && dialUp);

endmodule : prc_run_ctrl
